// [design/pxe_pkg.sv]
`default_nettype none
package pxe_pkg;

	// Slave address groups, upper three address bits
	localparam logic [2:0] PXE_GRP_HIGH  = 3'h5;
	localparam logic [2:0] PXE_GRP_LOW   = 3'h6;

	// Interrupt mask after power-up, bits 5..2 map to the input ports
	localparam logic [7:0] PXE_MASK_RST  = 8'h3c;

	// Register offsets of the local bus
	localparam logic [3:0] PXE_REG_STATUS = 4'h0;
	localparam logic [3:0] PXE_REG_IRQEN  = 4'h4;
	localparam logic [3:0] PXE_REG_PORTS  = 4'h8;
	localparam logic [3:0] PXE_REG_CTRL   = 4'hc;

	// Status bit positions
	localparam int PXE_ST_ADDR  = 0;
	localparam int PXE_ST_WRITE = 1;
	localparam int PXE_ST_TRANS = 2;

	// Reset values
	localparam logic [2:0]  PXE_STATUS_RST = 3'h0;
	localparam logic [2:0]  PXE_IRQEN_RST  = 3'h0;
	localparam logic        PXE_CTRL_RST   = 1'b1;
	localparam logic [10:0] PXE_SYNC_RST   = 11'h700;

	// Bits per byte, and cycles before transition detection is armed
	localparam logic [3:0] PXE_BYTE_BITS = 4'h8;
	localparam logic [1:0] PXE_PRIME_END = 2'h3;

	// Clock and bus rate
	localparam int PXE_CLK_HZ      = 20000000;
	localparam int PXE_SCL_MAX_HZ  = 400000;
	localparam int PXE_SCL_MIN_CYC = (PXE_CLK_HZ + PXE_SCL_MAX_HZ - 1) / PXE_SCL_MAX_HZ;

	typedef enum logic [2:0] {
		PXE_IDLE     = 3'b000,
		PXE_ADDR     = 3'b001,
		PXE_ADDR_ACK = 3'b010,
		PXE_WR_DATA  = 3'b011,
		PXE_WR_ACK   = 3'b100,
		PXE_RD_DATA  = 3'b101,
		PXE_RD_ACK   = 3'b110,
		PXE_IGNORE   = 3'b111
	} pxe_state_e;

endpackage
`default_nettype wire

// [design/pxe_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pxe_sync
	import pxe_pkg::*;
#(
	parameter int         W       = 12,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// Pins in, synchronised levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} pxe_sync_s;

	pxe_sync_s r;
	pxe_sync_s next_r;

	always_comb begin
		next_r        = r;
		next_r.meta   = d;
		next_r.stable = r.meta;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= {RST_VAL, RST_VAL};
		end else begin
			r <= next_r;
		end
	end

	assign q = r.stable;

endmodule
`default_nettype wire

// [design/pxe_expander.sv]
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pxe_expander
	import pxe_pkg::*;
#(
	parameter logic [11:0] DEFAULT_OUT = 12'h000
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Serial bus pins
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        serial_rst_n,
	// Address straps
	input  wire logic [1:0]  addr_sel_a,
	input  wire logic [1:0]  addr_sel_b,
	// Ports
	input  wire logic [3:0]  input_ports,
	output logic      [7:0]  upper_outputs,
	output logic             low_output_zero,
	output logic             low_output_one,
	output logic             low_output_six,
	output logic             low_output_seven,
	output logic             int_n,
	// Register bus
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq
);

	typedef struct packed {
		pxe_state_e  state;
		logic [3:0]  cnt;
		logic [7:0]  shift;
		logic [7:0]  tx;
		logic        grp_low;
		logic        byte_idx;
		logic        nack;
		logic        sda_low;
		logic        scl_prev;
		logic        sda_prev;
		logic [7:0]  upper;
		logic [3:0]  lowo;
		logic [3:0]  imask;
		logic [3:0]  in_prev;
		logic [1:0]  prime;
		logic [3:0]  flags;
		logic        int_n;
		logic [2:0]  status;
		logic [2:0]  irq_en;
		logic        slave_en;
		logic [31:0] rdata;
	} pxe_state_s;

	pxe_state_s q;
	pxe_state_s n;

	logic [10:0] sync_q;
	logic        scl_s;
	logic        sda_s;
	logic        srst_s;
	logic [3:0]  in_s;
	logic [3:0]  addr_lo;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic        addr_match;
	logic        addr_hit;
	logic [3:0]  chg;
	logic [7:0]  port_lvl;
	logic [2:0]  st_set;
	logic [2:0]  st_clr;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	pxe_sync #(
		.W       (11),
		.RST_VAL (PXE_SYNC_RST)
	) pxe_sync_inst (
		.ref_clk (ref_clk),
		.rst     (rst),
		.d       ({scl, sda_in, serial_rst_n, input_ports, addr_sel_b, addr_sel_a}),
		.q       (sync_q)
	);

	assign scl_s   = sync_q[10];
	assign sda_s   = sync_q[9];
	assign srst_s  = sync_q[8];
	assign in_s    = sync_q[7:4];
	assign addr_lo = sync_q[3:0];

	////////////////////////////////////////////////////////////////////////
	// Bus conditions

	// Edges of SCL sampled well inside the fastest bus period
	assign scl_rise = scl_s && !q.scl_prev;
	assign scl_fall = !scl_s && q.scl_prev;
	assign start_c  = q.scl_prev && scl_s && q.sda_prev && !sda_s;
	assign stop_c   = q.scl_prev && scl_s && !q.sda_prev && sda_s;

	// Two address groups sharing the strap bits
	assign addr_match = q.slave_en && (q.shift[4:1] == addr_lo) &&
		((q.shift[7:5] == PXE_GRP_HIGH) || (q.shift[7:5] == PXE_GRP_LOW));
	assign addr_hit   = (q.state == PXE_ADDR) && scl_fall && (q.cnt == PXE_BYTE_BITS) &&
		addr_match && srst_s;

	// Levels at the pins of the low group
	assign port_lvl = {q.lowo[3:2], in_s, q.lowo[1:0]};

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n          = q;
		n.scl_prev = scl_s;
		n.sda_prev = sda_s;
		st_set     = 3'h0;
		st_clr     = 3'h0;
		chg        = 4'h0;

		case (q.state)
			PXE_IDLE: begin
				n.sda_low = 1'b0;
			end
			PXE_ADDR: begin
				if (scl_rise) begin
					n.shift = {q.shift[6:0], sda_s};
					n.cnt   = q.cnt + 4'h1;
				end else if (scl_fall && (q.cnt == PXE_BYTE_BITS)) begin
					if (addr_match) begin
						n.state    = PXE_ADDR_ACK;
						n.sda_low  = 1'b1;
						n.grp_low  = (q.shift[7:5] == PXE_GRP_LOW);
						n.byte_idx = 1'b0;
						st_set[PXE_ST_ADDR] = 1'b1;
					end else begin
						n.state = PXE_IGNORE;
					end
				end
			end
			PXE_ADDR_ACK: begin
				if (scl_fall) begin
					n.cnt = 4'h0;
					if (q.shift[0]) begin
						n.tx      = q.grp_low ? port_lvl : q.upper;
						n.sda_low = q.grp_low ? !port_lvl[7] : !q.upper[7];
						n.state   = PXE_RD_DATA;
					end else begin
						n.sda_low = 1'b0;
						n.state   = PXE_WR_DATA;
					end
				end
			end
			PXE_WR_DATA: begin
				if (scl_rise) begin
					n.shift = {q.shift[6:0], sda_s};
					n.cnt   = q.cnt + 4'h1;
				end else if (scl_fall && (q.cnt == PXE_BYTE_BITS) && srst_s) begin
					if (!q.grp_low) begin
						n.upper = q.shift;
					end else if (!q.byte_idx) begin
						n.lowo = {q.shift[7:6], q.shift[1:0]};
					end else begin
						n.imask = q.shift[5:2];
					end
					n.byte_idx = 1'b1;
					n.sda_low  = 1'b1;
					n.state    = PXE_WR_ACK;
					st_set[PXE_ST_WRITE] = 1'b1;
				end
			end
			PXE_WR_ACK: begin
				if (scl_fall) begin
					n.sda_low = 1'b0;
					n.cnt     = 4'h0;
					n.state   = PXE_WR_DATA;
				end
			end
			PXE_RD_DATA: begin
				if (scl_rise) begin
					n.cnt = q.cnt + 4'h1;
				end else if (scl_fall) begin
					if (q.cnt == PXE_BYTE_BITS) begin
						n.sda_low = 1'b0;
						n.state   = PXE_RD_ACK;
					end else begin
						n.tx      = {q.tx[6:0], 1'b0};
						n.sda_low = !q.tx[6];
					end
				end
			end
			PXE_RD_ACK: begin
				if (scl_rise) begin
					n.nack = sda_s;
				end else if (scl_fall) begin
					n.cnt = 4'h0;
					if (q.nack) begin
						n.state = PXE_IGNORE;
					end else begin
						n.tx      = q.grp_low ? port_lvl : q.upper;
						n.sda_low = q.grp_low ? !port_lvl[7] : !q.upper[7];
						n.state   = PXE_RD_DATA;
					end
				end
			end
			PXE_IGNORE: begin
				n.sda_low = 1'b0;
			end
			default: begin
				n.state   = PXE_IDLE;
				n.sda_low = 1'b0;
			end
		endcase

		// Start and stop override the bit sequence
		if (start_c) begin
			n.state   = PXE_ADDR;
			n.cnt     = 4'h0;
			n.sda_low = 1'b0;
		end else if (stop_c) begin
			n.state   = PXE_IDLE;
			n.sda_low = 1'b0;
		end

		// Serial reset clears only the serial engine
		if (!srst_s) begin
			n.state   = PXE_IDLE;
			n.cnt     = 4'h0;
			n.sda_low = 1'b0;
		end

		// Transition detection, armed once synchronisers settle
		n.in_prev = in_s;
		if (q.prime != PXE_PRIME_END) begin
			n.prime = q.prime + 2'h1;
		end else begin
			chg = in_s ^ q.in_prev;
		end
		n.flags = (addr_hit ? 4'h0 : q.flags) | chg;
		n.int_n = !(|(n.flags & n.imask));
		st_set[PXE_ST_TRANS] = |chg;

		// Register bus
		n.rdata = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				PXE_REG_STATUS: st_clr     = reg_wdata[2:0];
				PXE_REG_IRQEN:  n.irq_en   = reg_wdata[2:0];
				PXE_REG_CTRL:   n.slave_en = reg_wdata[0];
				default: begin
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				PXE_REG_STATUS: n.rdata = {29'h0, q.status};
				PXE_REG_IRQEN:  n.rdata = {29'h0, q.irq_en};
				PXE_REG_PORTS:  n.rdata = {8'h0, q.flags, q.imask, q.upper, port_lvl};
				PXE_REG_CTRL:   n.rdata = {31'h0, q.slave_en};
				default:        n.rdata = 32'h0;
			endcase
		end
		n.status = (q.status & ~st_clr) | st_set;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q          <= '0;
			q.state    <= PXE_IDLE;
			q.scl_prev <= 1'b1;
			q.sda_prev <= 1'b1;
			q.upper    <= DEFAULT_OUT[11:4];
			q.lowo     <= DEFAULT_OUT[3:0];
			q.imask    <= PXE_MASK_RST[5:2];
			q.int_n    <= 1'b1;
			q.status   <= PXE_STATUS_RST;
			q.irq_en   <= PXE_IRQEN_RST;
			q.slave_en <= PXE_CTRL_RST;
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign sda_out          = 1'b0;
	assign sda_oe_n         = !q.sda_low;
	assign upper_outputs    = q.upper;
	assign low_output_zero  = q.lowo[0];
	assign low_output_one   = q.lowo[1];
	assign low_output_six   = q.lowo[2];
	assign low_output_seven = q.lowo[3];
	assign int_n            = q.int_n;
	assign reg_rdata        = q.rdata;
	assign irq              = |(q.status & q.irq_en);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_flag_set: assert property (
		(q.prime == PXE_PRIME_END) && (in_s != q.in_prev) |=>
		((q.flags & $past(in_s ^ q.in_prev)) == $past(in_s ^ q.in_prev)))
		else $error("transition flag not set");
	chk_flag_clear: assert property (
		addr_hit && (q.prime == PXE_PRIME_END) && (in_s == q.in_prev) |=>
		(q.flags == 4'h0) && int_n)
		else $error("flags not cleared on access");
	chk_int_mask: assert property (
		int_n == !(|(q.flags & q.imask)))
		else $error("interrupt pin disagrees with enabled flags");
	chk_high_write: assert property (
		(q.state == PXE_WR_DATA) && scl_fall && (q.cnt == PXE_BYTE_BITS) && !q.grp_low &&
		srst_s |=> (upper_outputs == $past(q.shift)) && !sda_oe_n)
		else $error("upper outputs not updated");
	chk_addr_group: assert property (
		(q.state == PXE_ADDR) && scl_fall && (q.cnt == PXE_BYTE_BITS) && q.slave_en &&
		(q.shift[7:5] == PXE_GRP_LOW) && (q.shift[4:1] == addr_lo) && srst_s && !start_c |=>
		(q.state == PXE_ADDR_ACK) && q.grp_low && !sda_oe_n)
		else $error("low group address not acknowledged");
	chk_addr_miss: assert property (
		(q.state == PXE_ADDR) && scl_fall && (q.cnt == PXE_BYTE_BITS) && !addr_match |=>
		sda_oe_n [*2])
		else $error("foreign address acknowledged");
	chk_srst_idle: assert property (
		!srst_s |=> (q.state == PXE_IDLE) && sda_oe_n)
		else $error("serial reset did not clear engine");
	chk_srst_int: assert property (
		!srst_s && (q.prime == PXE_PRIME_END) && (in_s == q.in_prev) && !addr_hit |=>
		$stable(q.flags) && $stable(int_n))
		else $error("serial reset touched interrupt state");
	chk_read_level: assert property (
		(q.state == PXE_ADDR_ACK) && scl_fall && q.shift[0] && q.grp_low && srst_s &&
		!start_c && !stop_c |=> (q.tx == $past(port_lvl)))
		else $error("read byte not taken from pin levels");

endmodule
`default_nettype wire

// [tb/pxe_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module pxe_i2c_master (
	// Clock
	input  wire logic ref_clk,
	// Bus wires, both idle high
	input  wire logic sda,
	output var logic  scl   = 1'b1,
	output var logic  sda_m = 1'b1
);
	////////////////////////////////////////////////////////////////
	// Quarter bit of 650 ns keeps the bus under 400 kHz
	task automatic q;
		repeat (13) @(posedge ref_clk);
	endtask

	task automatic bit_io(input logic b, output logic r);
		sda_m <= b;
		q();
		scl <= 1'b1;
		q();
		r = sda;
		q();
		scl <= 1'b0;
		q();
	endtask

	task automatic start;
		sda_m <= 1'b0;
		q();
		scl <= 1'b0;
		q();
	endtask

	task automatic stop;
		sda_m <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_m <= 1'b1;
		q();
	endtask

	// MSB first, then one acknowledge bit
	task automatic byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] r,
		output logic a_out);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(a_in, a_out);
	endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pxe_pkg::*;
	logic        ref_clk      = 1'b0;
	logic        rst          = 1'b1;
	logic        serial_rst_n = 1'b1;
	logic        reg_wr       = 1'b0;
	logic        reg_rd       = 1'b0;
	logic [1:0]  addr_sel_a   = 2'h1;
	logic [1:0]  addr_sel_b   = 2'h2;
	logic [3:0]  input_ports  = 4'h0;
	logic [3:0]  reg_addr     = 4'h0;
	logic [31:0] reg_wdata    = 32'h0;
	logic [7:0]  r;
	logic        ack;
	wire logic   scl;
	wire logic   sda_m;
	wire logic   sda;
	wire logic   sda_out;
	wire logic   sda_oe_n;
	wire logic   o0;
	wire logic   o1;
	wire logic   o6;
	wire logic   o7;
	wire logic   int_n;
	wire logic   irq;
	wire logic [7:0]  upper;
	wire logic [31:0] reg_rdata;
	int          err_total    = 0;
	int          n_tests      = 0;

	always #25 ref_clk = ~ref_clk;
	// Open-drain line with pull-up
	assign sda = sda_m & (sda_oe_n | sda_out);

	pxe_expander #(.DEFAULT_OUT(12'h5a3)) pxe_expander_inst (
		.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .serial_rst_n(serial_rst_n), .addr_sel_a(addr_sel_a),
		.addr_sel_b(addr_sel_b), .input_ports(input_ports), .upper_outputs(upper),
		.low_output_zero(o0), .low_output_one(o1), .low_output_six(o6),
		.low_output_seven(o7), .int_n(int_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq)
	);

	pxe_i2c_master pxe_i2c_master_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("wrong value %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), e, reg_rdata);
	endtask

	task automatic pls(input int b);
		@(posedge ref_clk) input_ports[b] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		input_ports[b] <= 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask

	task automatic xfer(input logic [7:0] a, input logic [7:0] d);
		logic t;
		pxe_i2c_master_inst.start();
		pxe_i2c_master_inst.byte_io(a, 1'b1, r, ack);
		pxe_i2c_master_inst.byte_io(d, 1'b1, r, t);
		pxe_i2c_master_inst.stop();
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("upper", 32'h5a, upper);
		rc(PXE_REG_PORTS, 32'h000f5a03);
		rc(PXE_REG_CTRL, 32'h1);
		rc(4'h2, 32'h0);
		pls(0);
		chk("int_n", 32'h0, int_n);
		rc(PXE_REG_PORTS, 32'h001f5a03);
		xfer(8'hb2, 8'ha5);
		chk("ack", 32'h0, ack);
		chk("upper", 32'ha5, upper);
		chk("int_n", 32'h1, int_n);
		xfer(8'hb4, 8'h00);
		chk("ack", 32'h1, ack);
		pxe_i2c_master_inst.start();
		pxe_i2c_master_inst.byte_io(8'hd2, 1'b1, r, ack);
		pxe_i2c_master_inst.byte_io(8'hc3, 1'b1, r, ack);
		pxe_i2c_master_inst.byte_io(8'h14, 1'b1, r, ack);
		pxe_i2c_master_inst.stop();
		chk("low", 32'hf, {o7, o6, o1, o0});
		rc(PXE_REG_PORTS, 32'h0005a5c3);
		pls(1);
		chk("int_n", 32'h1, int_n);
		pls(0);
		chk("int_n", 32'h0, int_n);
		pxe_i2c_master_inst.start();
		for (int i = 7; i >= 4; i--) begin
			pxe_i2c_master_inst.bit_io(1'(8'hb2 >> i), ack);
		end
		serial_rst_n <= 1'b0;
		repeat (20) @(posedge ref_clk);
		serial_rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int i = 3; i >= -1; i--) begin
			pxe_i2c_master_inst.bit_io(i < 0 ? 1'b1 : 1'(8'hb2 >> i), ack);
		end
		pxe_i2c_master_inst.stop();
		chk("ack", 32'h1, ack);
		chk("int_n", 32'h0, int_n);
		input_ports <= 4'ha;
		repeat (10) @(posedge ref_clk);
		xfer(8'hd3, 8'hff);
		chk("pins", 32'heb, r);
		chk("int_n", 32'h1, int_n);
		xfer(8'hb3, 8'hff);
		chk("upper rd", 32'ha5, r);
		rc(PXE_REG_STATUS, 32'h7);
		chk("irq", 32'h0, irq);
		wr(PXE_REG_IRQEN, 32'h4);
		chk("irq", 32'h1, irq);
		wr(PXE_REG_STATUS, 32'h7);
		chk("irq", 32'h0, irq);
		rc(PXE_REG_STATUS, 32'h0);
		wr(PXE_REG_CTRL, 32'h0);
		xfer(8'hb2, 8'h00);
		chk("ack", 32'h1, ack);
		wr(PXE_REG_CTRL, 32'h1);
		wr(PXE_REG_PORTS, 32'hffffffff);
		rc(PXE_REG_PORTS, 32'h0005a5eb);
		// Two-byte read, pins change after the address byte, while the first byte shifts out
		pxe_i2c_master_inst.start();
		pxe_i2c_master_inst.byte_io(8'hd3, 1'b1, r, ack);
		input_ports <= 4'h5;
		pxe_i2c_master_inst.byte_io(8'hff, 1'b0, r, ack);
		chk("rd first", 32'heb, r);
		pxe_i2c_master_inst.byte_io(8'hff, 1'b1, r, ack);
		pxe_i2c_master_inst.stop();
		chk("rd next", 32'hd7, r);
		chk("int_n", 32'h0, int_n);
		give_verdict();
	end
endmodule
`default_nettype wire
